// file: timer_pkg.sv
package timer_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int CNT_W    = 16;
	localparam int CHAN_N   = 4;
	localparam int PAIR_N   = 3;
	localparam int DEAD_W   = 8;
	localparam int HALL_N   = 3;
	localparam int DMA_N    = CHAN_N + 1;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [CNT_W-1:0]  CNT_RST  = 16'h0000;
	localparam logic [CNT_W-1:0]  PSC_RST  = 16'h0000;
	localparam logic [DEAD_W-1:0] DEAD_RST = 8'h00;

	// ------------------------------------------------------------
	// counting modes and channel modes
	// ------------------------------------------------------------
	typedef enum logic [2:0] {
		CNT_UP     = 3'b001,
		CNT_DOWN   = 3'b010,
		CNT_CENTER = 3'b100
	} cnt_mode_e;

	typedef enum logic [3:0] {
		CH_CAPTURE = 4'b0001,
		CH_COMPARE = 4'b0010,
		CH_PWM     = 4'b0100,
		CH_ONEPULS = 4'b1000
	} chan_mode_e;

	// ------------------------------------------------------------
	// configuration carriers
	// ------------------------------------------------------------
	typedef struct packed {
		cnt_mode_e        mode;
		logic             enable;
		logic             one_pulse;
		logic             encoder;
		logic             sync_start;
		logic             freeze_en;
		logic [CNT_W-1:0] prescale;
		logic [CNT_W-1:0] reload;
	} cnt_cfg_s;

	typedef struct packed {
		chan_mode_e       mode;
		logic [CNT_W-1:0] compare;
	} chan_cfg_s;

	typedef struct packed {
		logic              out_en;
		logic [DEAD_W-1:0] dead;
		logic [HALL_N-1:0] hall_en;
		logic [DMA_N-1:0]  dma_en;
	} drive_cfg_s;

endpackage : timer_pkg

// file: motor_control_pwm_timer.sv
`timescale 1ns/100ps

// Contract
// - auto-reload 16-bit counter counting up, down or up then down
// - 16-bit prescaler divides counter clock by any ratio 1 to 65536
// - four channels, each capture, compare, PWM or one-pulse
// - PWM edge-aligned, or centre-aligned using up/down counting
// - complementary outputs with programmable dead time between switchings
// - three complementary pairs give six phase outputs
// - duty cycle spans 0 to 100 percent, both ends reachable while reload is below FFFF
// - counter holds while processor halted in debug, if freeze enabled, unless a sync-start link trigger clears it
// - DMA requests from counter and channel events, independently
// - trigger exchange with other timers for synced start and chaining
// - quadrature encoder inputs drive counter up or down by direction
// - one to three hall sensor inputs captured for commutation timing
module motor_control_pwm_timer
	import timer_pkg::*;
#(
	parameter int CHANNELS = CHAN_N,
	parameter int PAIRS    = PAIR_N
) (
	// clock and reset
	input  wire logic                         clk_in,
	input  wire logic                         rst_in,
	// configuration
	input  wire cnt_cfg_s                     cnt_cfg_in,
	input  wire chan_cfg_s [CHANNELS-1:0]     chan_cfg_in,
	input  wire drive_cfg_s                   drive_cfg_in,
	// debug halt and timer link
	input  wire logic                         dbg_halt_in,
	input  wire logic                         trig_in,
	output logic                              trig_out,
	// pins from the field
	input  wire logic [CHANNELS-1:0]          cap_pin_in,
	input  wire logic                         enc_a_in,
	input  wire logic                         enc_b_in,
	input  wire logic [HALL_N-1:0]            hall_in,
	// pins to the power stage
	output logic      [CHANNELS-1:0]          pwm_out,
	output logic      [PAIRS-1:0]             pwm_n_out,
	// status and data
	output logic      [CNT_W-1:0]             count_out,
	output logic                              count_up_out,
	output logic                              running_out,
	output logic      [CHANNELS-1:0][CNT_W-1:0] capture_out,
	output logic      [CNT_W-1:0]             hall_capture_out,
	output logic                              hall_event_out,
	output logic      [CHANNELS:0]            dma_req_out
);

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	if (PAIRS > CHANNELS || CHANNELS < 1 || CHANNELS + 1 > DMA_N) begin : g_bad
		$error("unsupported channel or pair count");
	end

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	localparam int SYN_W = CHANNELS + 2 + HALL_N;
	logic [SYN_W-1:0] syn1_q;
	logic [SYN_W-1:0] syn2_q;
	logic [SYN_W-1:0] prev_q;

	// two stages, then one more for edge detection on clean levels
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			syn1_q <= '0;
			syn2_q <= '0;
			prev_q <= '0;
		end else begin
			syn1_q <= {hall_in, enc_b_in, enc_a_in, cap_pin_in};
			syn2_q <= syn1_q;
			prev_q <= syn2_q;
		end
	end

	logic enc_a, enc_b, enc_pa, enc_pb, enc_step, enc_up;
	assign enc_a    = syn2_q[CHANNELS];
	assign enc_b    = syn2_q[CHANNELS+1];
	assign enc_pa   = prev_q[CHANNELS];
	assign enc_pb   = prev_q[CHANNELS+1];
	// x4 decode; a double change is a lost step and is dropped
	assign enc_step = (enc_a ^ enc_pa) ^ (enc_b ^ enc_pb);
	assign enc_up   = enc_a ^ enc_pb;

	// ------------------------------------------------------------
	// prescaler and counter
	// ------------------------------------------------------------
	logic [CNT_W-1:0] cnt_q, cnt_d, psc_q, psc_d;
	logic             dir_q, dir_d, run_q, run_d, en_q;
	logic             advance, tick, up_now, upd, start;
	logic             any_onepulse;

	always_comb begin
		any_onepulse = 1'b0;
		for (int i = 0; i < CHANNELS; i++) begin
			if (chan_cfg_in[i].mode == CH_ONEPULS) begin
				any_onepulse = 1'b1;
			end
		end
	end

	// freeze only while halted and enabled
	assign advance = run_q & ~(cnt_cfg_in.freeze_en & dbg_halt_in);
	// either synchronised start by the link or a plain enable edge
	assign start = cnt_cfg_in.sync_start ? trig_in
	             : (cnt_cfg_in.enable & ~en_q);

	always_comb begin
		psc_d  = psc_q;
		cnt_d  = cnt_q;
		dir_d  = dir_q;
		upd    = 1'b0;
		tick   = 1'b0;
		up_now = 1'b1;
		if (cnt_cfg_in.encoder) begin
			tick   = advance & enc_step;
			up_now = enc_up;
		end else begin
			// ratio is prescale + 1, so 0..FFFF covers 1..65536
			if (advance) begin
				psc_d = (psc_q == cnt_cfg_in.prescale) ? PSC_RST
				      : psc_q + 16'h0001;
			end
			tick = advance & (psc_q == cnt_cfg_in.prescale);
			case (cnt_cfg_in.mode)
				CNT_UP:     up_now = 1'b1;
				CNT_DOWN:   up_now = 1'b0;
				CNT_CENTER: up_now = dir_q;
				default:    up_now = 1'b1;
			endcase
		end
		if (tick) begin
			if (!cnt_cfg_in.encoder && cnt_cfg_in.mode == CNT_CENTER) begin
				// centre mode turns round at both ends
				if (up_now && cnt_q >= cnt_cfg_in.reload) begin
					dir_d = 1'b0;
					cnt_d = (cnt_q == CNT_RST) ? CNT_RST : cnt_q - 16'h0001;
					upd   = 1'b1;
				end else if (!up_now && cnt_q == CNT_RST) begin
					dir_d = 1'b1;
					cnt_d = (cnt_cfg_in.reload == CNT_RST) ? CNT_RST
					      : cnt_q + 16'h0001;
					upd   = 1'b1;
				end else begin
					cnt_d = up_now ? cnt_q + 16'h0001 : cnt_q - 16'h0001;
				end
			end else if (up_now) begin
				dir_d = 1'b1;
				if (cnt_q >= cnt_cfg_in.reload) begin
					cnt_d = CNT_RST;
					upd   = 1'b1;
				end else begin
					cnt_d = cnt_q + 16'h0001;
				end
			end else begin
				dir_d = 1'b0;
				if (cnt_q == CNT_RST) begin
					cnt_d = cnt_cfg_in.reload;
					upd   = 1'b1;
				end else begin
					cnt_d = cnt_q - 16'h0001;
				end
			end
		end
		run_d = cnt_cfg_in.enable & (run_q | start);
		// one-pulse stops at the update; encoder mode never stops itself
		if (upd && !cnt_cfg_in.encoder
		    && (cnt_cfg_in.one_pulse || any_onepulse)) begin
			run_d = 1'b0;
		end
		if (cnt_cfg_in.sync_start && trig_in && cnt_cfg_in.enable) begin
			cnt_d = CNT_RST;
			psc_d = PSC_RST;
			dir_d = 1'b1;
		end
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			cnt_q <= CNT_RST;
			psc_q <= PSC_RST;
			dir_q <= 1'b1;
			run_q <= 1'b0;
			en_q  <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			psc_q <= psc_d;
			dir_q <= dir_d;
			run_q <= run_d;
			en_q  <= cnt_cfg_in.enable;
		end
	end

	assign count_out    = cnt_q;
	assign count_up_out = dir_q;
	assign running_out  = run_q;

	// ------------------------------------------------------------
	// channels with dead-time stage
	// ------------------------------------------------------------
	logic [CHANNELS-1:0] ch_evt;
	logic [CHANNELS-1:0] pn_q;

	for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
		logic [CNT_W-1:0]  cap_q, cap_d;
		logic              tog_q, tog_d, ref_q, ref_d, p_q, p_d, n_d;
		logic [DEAD_W-1:0] dt_q, dt_d;
		logic              cref, edge_in, match;

		assign edge_in = syn2_q[i] & ~prev_q[i];
		assign match   = tick & (cnt_q == chan_cfg_in[i].compare);

		always_comb begin
			cap_d     = cap_q;
			tog_d     = tog_q;
			cref      = 1'b0;
			ch_evt[i] = 1'b0;
			case (chan_cfg_in[i].mode)
				CH_CAPTURE: begin
					if (edge_in) begin
						cap_d     = cnt_q;
						ch_evt[i] = 1'b1;
					end
				end
				CH_COMPARE: begin
					if (match) begin
						tog_d     = ~tog_q;
						ch_evt[i] = 1'b1;
					end
					cref = tog_q;
				end
				CH_PWM: begin
					// compare 0 gives 0%, compare above reload gives 100%
					cref      = cnt_q < chan_cfg_in[i].compare;
					ch_evt[i] = match;
				end
				CH_ONEPULS: begin
					cref      = run_q & (cnt_q >= chan_cfg_in[i].compare);
					ch_evt[i] = match;
				end
				default: cref = 1'b0;
			endcase
			// any change of reference restarts the dead interval
			ref_d = cref;
			dt_d  = dt_q;
			if (cref != ref_q) begin
				dt_d = drive_cfg_in.dead;
			end else if (dt_q != DEAD_RST) begin
				dt_d = dt_q - 8'h01;
			end
			// both sides low while the interval runs
			p_d = drive_cfg_in.out_en & ref_d & (dt_d == DEAD_RST);
			n_d = drive_cfg_in.out_en & ~ref_d & (dt_d == DEAD_RST);
		end

		always_ff @(posedge clk_in or posedge rst_in) begin
			if (rst_in) begin
				cap_q    <= CNT_RST;
				tog_q    <= 1'b0;
				ref_q    <= 1'b0;
				dt_q     <= DEAD_RST;
				p_q      <= 1'b0;
				pn_q[i]  <= 1'b0;
			end else begin
				cap_q    <= cap_d;
				tog_q    <= tog_d;
				ref_q    <= ref_d;
				dt_q     <= dt_d;
				p_q      <= p_d;
				pn_q[i]  <= n_d;
			end
		end

		assign pwm_out[i]     = p_q;
		assign capture_out[i] = cap_q;
		// only the first pairs have a complement pin
		if (i < PAIRS) begin : g_pair
			assign pwm_n_out[i] = pn_q[i];
		end
	end

	// ------------------------------------------------------------
	// hall sensors, trigger out and DMA requests
	// ------------------------------------------------------------
	logic [CNT_W-1:0]   hall_cap_q, hall_cap_d;
	logic               hall_evt_q, hall_evt_d, trig_q;
	logic [CHANNELS:0]  dma_q, dma_d;
	logic [HALL_N-1:0]  hall_now, hall_old;

	assign hall_now = syn2_q[SYN_W-1 -: HALL_N];
	assign hall_old = prev_q[SYN_W-1 -: HALL_N];

	always_comb begin
		// unused sensors are masked so one to three may be fitted
		hall_evt_d = |((hall_now ^ hall_old) & drive_cfg_in.hall_en);
		hall_cap_d = hall_evt_d ? cnt_q : hall_cap_q;
		dma_d      = {ch_evt, upd}
		           & drive_cfg_in.dma_en[CHANNELS:0];
	end

	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			hall_cap_q <= CNT_RST;
			hall_evt_q <= 1'b0;
			dma_q      <= '0;
			trig_q     <= 1'b0;
		end else begin
			hall_cap_q <= hall_cap_d;
			hall_evt_q <= hall_evt_d;
			dma_q      <= dma_d;
			trig_q     <= upd;
		end
	end

	assign hall_capture_out = hall_cap_q;
	assign hall_event_out   = hall_evt_q;
	assign dma_req_out      = dma_q;
	assign trig_out         = trig_q;

endmodule : motor_control_pwm_timer

// file: pwm_timer_checker.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// port-level checks for the pwm timer
// ------------------------------------------------------------
module pwm_timer_checker
	import timer_pkg::*;
#(
	parameter int CHANNELS = CHAN_N,
	parameter int PAIRS    = PAIR_N
) (
	// clock and reset
	input wire logic                      clk_in,
	input wire logic                      rst_in,
	// configuration and control
	input wire cnt_cfg_s                  cnt_cfg_in,
	input wire chan_cfg_s [CHANNELS-1:0]  chan_cfg_in,
	input wire drive_cfg_s                drive_cfg_in,
	input wire logic                      dbg_halt_in,
	input wire logic                      trig_in,
	// timer outputs
	input wire logic                      trig_out,
	input wire logic [CHANNELS-1:0]       pwm_out,
	input wire logic [PAIRS-1:0]          pwm_n_out,
	input wire logic [CNT_W-1:0]          count_out,
	input wire logic                      running_out,
	input wire logic [CHANNELS-1:0][CNT_W-1:0] capture_out,
	input wire logic [CHANNELS:0]         dma_req_out
);
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	// shoot-through would short the supply rail
	chk_no_overlap: assert property (
		(pwm_out[PAIRS-1:0] & pwm_n_out) == '0) else $error("pair both high");
	chk_update_dma: assert property (
		trig_out && drive_cfg_in.dma_en[0] |-> dma_req_out[0])
		else $error("update without dma request");
	chk_debug_freeze: assert property (
		running_out && cnt_cfg_in.enable && dbg_halt_in && !trig_in
		&& cnt_cfg_in.freeze_en |=> $stable(count_out)) else $error("count moved");
	chk_outputs_off: assert property (
		!drive_cfg_in.out_en |=> pwm_out == '0 && pwm_n_out == '0)
		else $error("outputs live while disabled");
	chk_count_range: assert property (
		running_out && !cnt_cfg_in.encoder |-> count_out <= cnt_cfg_in.reload)
		else $error("count above reload");
	chk_up_step: assert property (
		running_out && cnt_cfg_in.enable && cnt_cfg_in.mode == CNT_UP
		&& cnt_cfg_in.prescale == '0 && !cnt_cfg_in.encoder && !dbg_halt_in
		&& !trig_in && count_out < cnt_cfg_in.reload
		|=> count_out == $past(count_out) + 16'h0001) else $error("bad up step");
	chk_prescale_gap: assert property (
		running_out && cnt_cfg_in.enable && !cnt_cfg_in.encoder
		&& !cnt_cfg_in.sync_start && cnt_cfg_in.prescale != '0
		&& $changed(count_out) |=> $stable(count_out)) else $error("no prescale");
	chk_zero_duty: assert property (
		(chan_cfg_in[0].mode == CH_PWM && chan_cfg_in[0].compare == '0) [*4]
		|-> !pwm_out[0]) else $error("zero duty output high");
	chk_capture_dma: assert property (
		$changed(capture_out[1]) && drive_cfg_in.dma_en[2]
		|-> ##[0:1] dma_req_out[2]) else $error("capture without dma");

	// main scenarios reached
	cover property (trig_out);
	cover property (dma_req_out[2]);
	cover property (running_out && dbg_halt_in && cnt_cfg_in.freeze_en);
endmodule : pwm_timer_checker

bind motor_control_pwm_timer pwm_timer_checker #(
	.CHANNELS(CHANNELS), .PAIRS(PAIRS)) chk (
	.clk_in(clk_in), .rst_in(rst_in), .cnt_cfg_in(cnt_cfg_in),
	.chan_cfg_in(chan_cfg_in), .drive_cfg_in(drive_cfg_in),
	.dbg_halt_in(dbg_halt_in), .trig_in(trig_in), .trig_out(trig_out),
	.pwm_out(pwm_out), .pwm_n_out(pwm_n_out), .count_out(count_out),
	.running_out(running_out), .capture_out(capture_out),
	.dma_req_out(dma_req_out));

// file: field_model.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// encoder, hall sensors and capture sources in the field
// ------------------------------------------------------------
module field_model (
	// clock
	input  wire logic clk_in,
	// pins towards the timer
	output logic       enc_a_out,
	output logic       enc_b_out,
	output logic [2:0] hall_out,
	output logic [3:0] cap_out
);
	logic [1:0] phase_q;

	// all pins idle low at power up
	initial begin
		phase_q = 2'h0;
		enc_a_out = 1'b0;
		enc_b_out = 1'b0;
		hall_out = 3'h0;
		cap_out = 4'h0;
	end

	// gray step; spacing outlasts the two-flop pin sync
	task automatic enc_step(input logic fwd);
		phase_q = fwd ? phase_q + 2'h1 : phase_q - 2'h1;
		@(posedge clk_in);
		enc_a_out <= phase_q[1] ^ phase_q[0];
		enc_b_out <= phase_q[1];
		repeat (5) @(posedge clk_in);
	endtask : enc_step

	// one sensor changes level
	task automatic hall_flip(input int i);
		@(posedge clk_in);
		hall_out[i] <= ~hall_out[i];
		repeat (6) @(posedge clk_in);
	endtask : hall_flip

	// pulse wide enough to survive the sync
	task automatic cap_pulse(input int i);
		@(posedge clk_in);
		cap_out[i] <= 1'b1;
		repeat (3) @(posedge clk_in);
		cap_out[i] <= 1'b0;
		repeat (4) @(posedge clk_in);
	endtask : cap_pulse
endmodule : field_model

// file: testbench.sv
`timescale 1ns/100ps

// ------------------------------------------------------------
// self-checking bench for the pwm timer
// ------------------------------------------------------------
module testbench
	import timer_pkg::*;
;
	logic clk_in, rst_in, dbg_halt, trig_in, trig_o, running, count_up;
	logic hall_ev, enc_a, enc_b;
	cnt_cfg_s          cc;
	chan_cfg_s [3:0]   ch;
	drive_cfg_s        dc;
	logic [3:0]        pwm, cap;
	logic [2:0]        pwm_n, hall;
	logic [15:0]       count, hall_cap;
	logic [3:0][15:0]  capt;
	logic [4:0]        dma;
	int fail_count, cmp_count, cyc, hall_seen, w;

	motor_control_pwm_timer dut (.clk_in(clk_in), .rst_in(rst_in),
		.cnt_cfg_in(cc), .chan_cfg_in(ch), .drive_cfg_in(dc),
		.dbg_halt_in(dbg_halt), .trig_in(trig_in), .trig_out(trig_o),
		.cap_pin_in(cap), .enc_a_in(enc_a), .enc_b_in(enc_b),
		.hall_in(hall), .pwm_out(pwm), .pwm_n_out(pwm_n), .count_out(count),
		.count_up_out(count_up), .running_out(running),
		.capture_out(capt), .hall_capture_out(hall_cap),
		.hall_event_out(hall_ev), .dma_req_out(dma));
	field_model fm (.clk_in(clk_in), .enc_a_out(enc_a), .enc_b_out(enc_b),
		.hall_out(hall), .cap_out(cap));

	// 8 ns clock
	initial begin
		clk_in = 1'b0;
		forever #4 clk_in = ~clk_in;
	end

	// hang guard and hall pulse tally
	always @(posedge clk_in) begin
		cyc++;
		if (hall_ev === 1'b1) hall_seen++;
		if (cyc == 20000) begin
			fail_count++;
			end_of_test();
		end
	end

	task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// reset held four cycles, config back to idle
	task automatic reset_dut();
		rst_in <= 1'b1;
		cc <= '{mode: CNT_UP, prescale: 16'h0000, reload: 16'hFFFF,
			default: 1'b0};
		ch <= '{default: '{CH_COMPARE, 16'h0000}};
		dc <= '{dead: 8'h00, hall_en: 3'h0, dma_en: 5'h1F, out_en: 1'b1};
		dbg_halt <= 1'b0;
		trig_in <= 1'b0;
		repeat (4) @(posedge clk_in);
		rst_in <= 1'b0;
		@(posedge clk_in);
	endtask : reset_dut

	task automatic wait_trig(output int n);
		n = 0;
		do begin
			@(posedge clk_in);
			n++;
		end while (trig_o !== 1'b1 && n < 500);
	endtask : wait_trig

	task automatic t_modes();
		cnt_mode_e m;
		int n;
		for (int i = 0; i < 3; i++) begin
			m = cnt_mode_e'(3'h1 << i);
			reset_dut();
			cc.mode <= m;
			cc.prescale <= 16'h0002;
			cc.reload <= 16'h0004;
			cc.enable <= 1'b1;
			wait_trig(n);
			wait_trig(n);
			check("period", 16'(n), m == CNT_CENTER ? 16'h000C : 16'h000F);
			// down mode counts down; up and centre end this update going up
			check("direction", {15'h0, count_up}, {15'h0, m != CNT_DOWN});
		end
	endtask : t_modes

	task automatic t_freeze_capture();
		logic [15:0] held;
		reset_dut();
		cc.freeze_en <= 1'b1;
		cc.enable <= 1'b1;
		ch[1] <= '{CH_CAPTURE, 16'h0000};
		repeat (10) @(posedge clk_in);
		dbg_halt <= 1'b1;
		repeat (3) @(posedge clk_in);
		held = count;
		fm.cap_pulse(1);
		check("frozen count", count, held);
		check("capture", capt[1], held);
		cc.freeze_en <= 1'b0;
		repeat (3) @(posedge clk_in);
		check("count runs", {15'h0, count !== held}, 16'h0001);
	endtask : t_freeze_capture

	task automatic t_duty();
		logic [3:0] any_hi, all_hi;
		reset_dut();
		cc.reload <= 16'h0009;
		dc.dead <= 8'h03;
		ch[0] <= '{CH_PWM, 16'h0000};
		ch[1] <= '{CH_PWM, 16'h000A};
		ch[2] <= '{CH_PWM, 16'h0005};
		cc.enable <= 1'b1;
		repeat (30) @(posedge clk_in);
		any_hi = {1'b0, pwm_n};
		all_hi = pwm;
		repeat (20) begin
			@(posedge clk_in);
			any_hi |= {1'b0, pwm_n};
			all_hi &= pwm;
		end
		check("zero duty", {15'h0, pwm[0] | ~any_hi[0]}, 16'h0000);
		check("full duty", {15'h0, all_hi[1] & ~any_hi[1]}, 16'h0001);
		w = 0;
		while (pwm[2] !== 1'b1 && w < 40) begin
			@(posedge clk_in);
			w++;
		end
		while (pwm[2] !== 1'b0 && w < 80) begin
			@(posedge clk_in);
			w++;
		end
		w = 0;
		while (pwm_n[2] !== 1'b1 && w < 40) begin
			@(posedge clk_in);
			w++;
		end
		check("dead gap", 16'(w), 16'h0003);
		// output enable off must park both sides of every pair low
		dc.out_en <= 1'b0;
		repeat (2) @(posedge clk_in);
		check("outputs off", {9'h0, pwm_n, pwm}, 16'h0000);
	endtask : t_duty

	task automatic t_link();
		reset_dut();
		// enabled but armed: only the link trigger may start it
		cc.sync_start <= 1'b1;
		cc.enable <= 1'b1;
		repeat (2) @(posedge clk_in);
		check("idle", {15'h0, running}, 16'h0000);
		trig_in <= 1'b1;
		@(posedge clk_in);
		trig_in <= 1'b0;
		@(posedge clk_in);
		check("linked start", {15'h0, running}, 16'h0001);
	endtask : t_link

	task automatic t_hall();
		int base;
		reset_dut();
		dc.hall_en <= 3'h2;
		cc.enable <= 1'b1;
		repeat (4) @(posedge clk_in);
		base = hall_seen;
		fm.hall_flip(1);
		check("hall event", 16'(hall_seen - base), 16'h0001);
		fm.hall_flip(0);
		check("masked hall", 16'(hall_seen - base), 16'h0001);
	endtask : t_hall

	// last, since it leaves the encoder pins away from idle
	task automatic t_encoder();
		reset_dut();
		cc.encoder <= 1'b1;
		cc.enable <= 1'b1;
		repeat (3) @(posedge clk_in);
		repeat (8) fm.enc_step(1'b1);
		repeat (3) fm.enc_step(1'b0);
		repeat (4) @(posedge clk_in);
		check("encoder count", count, 16'h0005);
	endtask : t_encoder

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : end_of_test

	// main sequence
	initial begin
		fail_count = 0;
		cmp_count = 0;
		cyc = 0;
		hall_seen = 0;
		reset_dut();
		t_modes();
		t_freeze_capture();
		t_duty();
		t_link();
		t_hall();
		t_encoder();
		end_of_test();
	end
endmodule : testbench
